// [verilog/sns_alu.sv]
`timescale 1ns/100ps
`default_nettype none
module sns_alu (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_insn_valid,
   input wire logic [sns_pkg::SNS_IW-1:0] i_insn,
   input wire logic [sns_pkg::SNS_DW-1:0] i_file_rdata,
   input wire sns_pkg::sns_flags_t i_flags,
   output logic [sns_pkg::SNS_AW-1:0] o_file_raddr,
   output sns_pkg::sns_fwr_t o_file_wr,
   output sns_pkg::sns_flags_t o_flags,
   output logic o_flags_we,
   output logic [sns_pkg::SNS_DW-1:0] o_accum,
   output logic o_done
);
   import sns_pkg::*;

   function automatic logic [1:0] decode(input logic [SNS_IW-1:0] insn);
      logic [SNS_IW-SNS_OP_LSB-1:0] op;
      op = insn[SNS_IW-1:SNS_OP_LSB];
      decode = {op == SNS_OP_SWAP, op == SNS_OP_SUB};
   endfunction : decode

   logic [1:0] dec;
   logic is_sub;
   logic is_swap;
   logic to_file;
   logic [SNS_AW-1:0] addr;
   logic [SNS_DW:0] diff;
   logic [SNS_NIB:0] ldiff;
   logic [SNS_DW-1:0] result;
   logic w_we;
   sns_fwr_t next_file_wr;
   sns_flags_t next_flags;
   logic next_flags_we;
   logic next_done;

   // The file address is sent combinationally from the raw instruction, so the
   // register file must return read data in the same cycle.
   assign dec = decode(i_insn);
   assign addr = i_insn[SNS_AW-1:0];

   // The swap is pure wiring; each bit lands one nibble away, so it costs no logic.
   wire logic [SNS_DW-1:0] swapped;
   genvar gi;
   generate
      for (gi = 0; gi < SNS_NIB; gi = gi + 1) begin : g_swap
         assign swapped[gi] = i_file_rdata[gi + SNS_NIB];
         assign swapped[gi + SNS_NIB] = i_file_rdata[gi];
      end
   endgenerate

   always_comb begin
      o_file_raddr = addr;
   end

   sns_wreg u_wreg (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n),
      .i_we(w_we),
      .i_wdata(result),
      .o_rdata(o_accum)
   );

   always_comb begin
      is_sub = i_insn_valid && dec[0];
      is_swap = i_insn_valid && dec[1];
      to_file = i_insn[SNS_D_BIT];
      // A ninth bit keeps the borrow, so carry needs no separate compare.
      diff = {1'b0, i_file_rdata} - {1'b0, o_accum};
      ldiff = {1'b0, i_file_rdata[SNS_NIB-1:0]} - {1'b0, o_accum[SNS_NIB-1:0]};
      result = is_swap ? swapped : diff[SNS_DW-1:0];
      w_we = (is_sub || is_swap) && !to_file;
      next_file_wr.valid = (is_sub || is_swap) && to_file;
      next_file_wr.addr = addr;
      next_file_wr.data = result;
      next_flags = o_flags;
      next_flags_we = 1'b0;
      if (is_sub) begin
         next_flags.carry = ~diff[SNS_DW];
         next_flags.digit_carry_flag = ~ldiff[SNS_NIB];
         next_flags.zero = (diff[SNS_DW-1:0] == '0);
         next_flags_we = 1'b1;
      end else begin
         next_flags = i_flags;
      end
      next_done = is_sub || is_swap;
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_file_wr <= '0;
         o_flags <= '0;
         o_flags_we <= 1'b0;
         o_done <= 1'b0;
      end else begin
         o_file_wr <= next_file_wr;
         o_flags <= next_flags;
         o_flags_we <= next_flags_we;
         o_done <= next_done;
      end
   end

   // Issue cycles of the accepted instructions, split by where the result goes, then the cycles with no accepted instruction.
   sequence seq_sub_to_file;
      is_sub && to_file;
   endsequence : seq_sub_to_file

   sequence seq_sub_to_accum;
      is_sub && !to_file;
   endsequence : seq_sub_to_accum

   sequence seq_swap_to_file;
      is_swap && to_file;
   endsequence : seq_swap_to_file

   sequence seq_swap_to_accum;
      is_swap && !to_file;
   endsequence : seq_swap_to_accum

   sequence seq_no_op;
      !is_sub && !is_swap;
   endsequence : seq_no_op

   // Results register one edge after issue, so each check looks back one edge.
   a_sub_carry: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      is_sub && i_file_rdata >= o_accum |=> o_flags.carry)
      else $error("carry wrong");

   a_sub_borrow: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      is_sub && i_file_rdata < o_accum |=> !o_flags.carry)
      else $error("borrow wrong");

   a_sub_dc_set: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      is_sub && i_file_rdata[SNS_NIB-1:0] >= o_accum[SNS_NIB-1:0]
         |=> o_flags.digit_carry_flag)
      else $error("digit carry not set");

   a_sub_dc_clear: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      is_sub && i_file_rdata[SNS_NIB-1:0] < o_accum[SNS_NIB-1:0]
         |=> !o_flags.digit_carry_flag)
      else $error("digit carry not cleared");

   a_sub_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      is_sub && i_file_rdata == o_accum |=> o_flags.zero)
      else $error("zero wrong");

   a_sub_zero_clear: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      is_sub && i_file_rdata != o_accum |=> !o_flags.zero)
      else $error("zero not cleared");

   a_sub_flags_we: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      is_sub |=> o_flags_we)
      else $error("subtract did not write flags");

   a_sub_file: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      seq_sub_to_file |=> o_file_wr.valid
         && o_file_wr.data == $past(i_file_rdata) - $past(o_accum))
      else $error("sub file write wrong");

   a_sub_file_addr: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      seq_sub_to_file |=> o_file_wr.addr == $past(i_insn[SNS_AW-1:0]))
      else $error("sub file address wrong");

   a_sub_accum: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      seq_sub_to_accum |=> !o_file_wr.valid
         && o_accum == $past(i_file_rdata) - $past(o_accum))
      else $error("sub accum write wrong");

   a_sub_accum_keep: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      seq_sub_to_file |=> o_accum == $past(o_accum))
      else $error("sub to file changed accum");

   a_swap_keeps_flags: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      is_swap |=> !o_flags_we)
      else $error("swap changed flags");

   a_swap_flags_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      is_swap |=> o_flags == $past(i_flags))
      else $error("swap altered flag values");

   a_swap_file: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      seq_swap_to_file |=> o_file_wr.data[SNS_NIB-1:0] == $past(i_file_rdata[SNS_DW-1:SNS_NIB]))
      else $error("swap file data wrong");

   a_swap_file_high: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      seq_swap_to_file |=> o_file_wr.data[SNS_DW-1:SNS_NIB] == $past(i_file_rdata[SNS_NIB-1:0]))
      else $error("swap file high nibble wrong");

   a_swap_file_write: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      seq_swap_to_file |=> o_file_wr.valid && o_file_wr.addr == $past(i_insn[SNS_AW-1:0]))
      else $error("swap file write missing");

   a_swap_accum: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      seq_swap_to_accum |=> o_accum[SNS_DW-1:SNS_NIB] == $past(i_file_rdata[SNS_NIB-1:0]))
      else $error("swap accum wrong");

   a_swap_accum_low: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      seq_swap_to_accum |=> o_accum[SNS_NIB-1:0] == $past(i_file_rdata[SNS_DW-1:SNS_NIB]))
      else $error("swap accum low nibble wrong");

   a_swap_no_file: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      seq_swap_to_accum |=> !o_file_wr.valid)
      else $error("swap to accum wrote the file");

   a_swap_accum_keep: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      seq_swap_to_file |=> o_accum == $past(o_accum))
      else $error("swap to file changed accum");

   a_one_cycle: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      (is_sub || is_swap) |=> o_done)
      else $error("not done in one cycle");

   a_idle_quiet: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      seq_no_op |=> !o_done && !o_file_wr.valid)
      else $error("action without an accepted instruction");

   a_idle_accum_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      seq_no_op |=> o_accum == $past(o_accum))
      else $error("accum changed while idle");

   a_flags_write_gate: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      !is_sub |=> !o_flags_we)
      else $error("flags written without a subtract");
endmodule : sns_alu
`default_nettype wire

// [verilog/sns_pkg.sv]
package sns_pkg;
   localparam int SNS_IW = 12;
   localparam int SNS_DW = 8;
   localparam int SNS_AW = 5;
   localparam int SNS_NIB = 4;
   localparam logic [5:0] SNS_OP_SUB = 6'h02;
   localparam logic [5:0] SNS_OP_SWAP = 6'h0E;
   localparam int SNS_OP_LSB = 6;
   localparam int SNS_D_BIT = 5;
   localparam logic [SNS_DW-1:0] SNS_W_RST = 8'h00;
   localparam logic [SNS_AW-1:0] SNS_F_MAX = 5'h1F;

   typedef struct packed {
      logic carry;
      logic digit_carry_flag;
      logic zero;
   } sns_flags_t;

   typedef struct packed {
      logic valid;
      logic [SNS_AW-1:0] addr;
      logic [SNS_DW-1:0] data;
   } sns_fwr_t;
endpackage : sns_pkg

// [verilog/sns_wreg.sv]
`timescale 1ns/100ps
`default_nettype none
// Holds the working accumulator; read data come straight from the register.
module sns_wreg (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_we,
   input wire logic [sns_pkg::SNS_DW-1:0] i_wdata,
   output logic [sns_pkg::SNS_DW-1:0] o_rdata
);
   import sns_pkg::*;
   logic [SNS_DW-1:0] next_rdata;

   always_comb begin
      next_rdata = i_we ? i_wdata : o_rdata;
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rdata <= SNS_W_RST;
      end else begin
         o_rdata <= next_rdata;
      end
   end
endmodule : sns_wreg
`default_nettype wire

// [test/sns_rf_model.sv]
`timescale 1ns/100ps
`default_nettype none
// Register file stand-in; the read is combinational, as the core's file read is.
module sns_rf_model (
   input wire logic i_ref_clk,
   input wire logic [sns_pkg::SNS_AW-1:0] i_raddr,
   input wire sns_pkg::sns_fwr_t i_wr,
   output logic [sns_pkg::SNS_DW-1:0] o_rdata
);
   import sns_pkg::*;
   logic [SNS_DW-1:0] mem [0:31];
   assign o_rdata = mem[i_raddr];
   always @(posedge i_ref_clk) begin
      if (i_wr.valid === 1'b1) begin
         mem[i_wr.addr] <= i_wr.data;
      end
   end
endmodule : sns_rf_model
`default_nettype wire

// [test/tb.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; \
   $display("BAD %0t got %h want %h", $time, a, b); end end
module tb;
   import sns_pkg::*;
   logic i_ref_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_insn_valid = 1'b0;
   logic [SNS_IW-1:0] i_insn = 12'h000;
   sns_flags_t i_flags = 3'h5;
   logic [SNS_DW-1:0] rdata, o_accum;
   logic [SNS_AW-1:0] raddr;
   sns_fwr_t o_file_wr;
   sns_flags_t o_flags;
   logic o_flags_we, o_done;
   int num_errors = 0;
   int n_compared = 0;
   always #2 i_ref_clk = ~i_ref_clk;
   sns_alu sns_alu_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_insn_valid(i_insn_valid),
      .i_insn(i_insn), .i_file_rdata(rdata), .i_flags(i_flags), .o_file_raddr(raddr),
      .o_file_wr(o_file_wr), .o_flags(o_flags), .o_flags_we(o_flags_we),
      .o_accum(o_accum), .o_done(o_done));
   sns_rf_model sns_rf_model_i (.i_ref_clk(i_ref_clk), .i_raddr(raddr), .i_wr(o_file_wr),
      .o_rdata(rdata));
   task automatic op(input logic [5:0] code, input logic d, input logic [4:0] f);
      @(posedge i_ref_clk);
      i_insn <= {code, d, f};
      i_insn_valid <= 1'b1;
      @(posedge i_ref_clk);
      i_insn_valid <= 1'b0;
      #1;
   endtask : op
   task automatic t_sub(input logic [7:0] fv, input logic [7:0] w, input logic d);
      logic [7:0] r;
      sns_flags_t ef;
      r = fv - w;
      ef.carry = (fv >= w);
      ef.digit_carry_flag = (fv[3:0] >= w[3:0]);
      ef.zero = (r == 8'h00);
      sns_rf_model_i.mem[30] = {w[3:0], w[7:4]};
      op(SNS_OP_SWAP, 1'b0, 5'h1E);
      `CHK(o_accum, w)
      sns_rf_model_i.mem[31] = fv;
      op(SNS_OP_SUB, d, SNS_F_MAX);
      `CHK(o_done, 1'b1)
      `CHK(o_flags_we, 1'b1)
      `CHK(o_flags, ef)
      `CHK(o_file_wr.valid, d)
      if (d) `CHK(({o_file_wr.addr, o_file_wr.data}), ({SNS_F_MAX, r}))
      `CHK(o_accum, d ? w : r)
   endtask : t_sub
   task automatic t_swap(input logic [7:0] fv, input logic d, input sns_flags_t fl);
      logic [7:0] s;
      s = {fv[3:0], fv[7:4]};
      sns_rf_model_i.mem[7] = fv;
      @(posedge i_ref_clk);
      i_flags <= fl;
      op(SNS_OP_SWAP, d, 5'h07);
      `CHK(o_done, 1'b1)
      `CHK(o_flags_we, 1'b0)
      `CHK(o_flags, fl)
      `CHK(o_file_wr.valid, d)
      `CHK(raddr, 5'h07)
      `CHK(d ? o_file_wr.data : o_accum, s)
   endtask : t_swap
   task automatic t_refuse;
      op(6'h0D, 1'b1, 5'h01);
      `CHK(o_done, 1'b0)
      `CHK(o_file_wr.valid, 1'b0)
      `CHK(o_flags_we, 1'b0)
   endtask : t_refuse
   task automatic end_of_test;
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_of_test
   initial begin
      #8000;
      num_errors++;
      end_of_test;
   end
   initial begin
      repeat (5) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      t_sub(8'h03, 8'h02, 1'b1);
      t_sub(8'h02, 8'h02, 1'b0);
      t_sub(8'h01, 8'h02, 1'b1);
      t_sub(8'h20, 8'h01, 1'b0);
      t_swap(8'hA5, 1'b0, 3'h2);
      t_swap(8'h3C, 1'b1, 3'h5);
      t_refuse;
      end_of_test;
   end
endmodule : tb
`default_nettype wire
